// ---- include/pvb_csr_pkg.sv ----
// constants for the bridge control/status register map
// assumes the map sits in one 4 KB space of 32-bit words
package pvb_csr_pkg;

   // ==========================================================
   // space and window geometry
   localparam int PVB_SPACE_BYTES = 4096;
   localparam int PVB_OFF_W = 12;
   localparam int PVB_BP_ADDR_W = 19;
   // 508 KB base added to every offset in CR/CSR space
   localparam logic [18:0] PVB_CRCSR_BASE = 19'h7f000;

   // ==========================================================
   // group boundaries
   localparam logic [11:0] PVB_HOST_CFG_END = 12'h100;
   localparam logic [11:0] PVB_BACKPLANE_START = 12'hf70;

   // ==========================================================
   // backplane csr words at the top of the map
   localparam logic [11:0] PVB_CSR_CLR_OFF = 12'hff4;
   localparam logic [11:0] PVB_CSR_SET_OFF = 12'hff8;
   localparam logic [11:0] PVB_CSR_BASE_OFF = 12'hffc;

   // ==========================================================
   // reset values
   localparam logic [31:0] PVB_REG_RESET = 32'h0000_0000;
   localparam logic [31:0] PVB_UNMAPPED_DATA = 32'h0000_0000;

   // ==========================================================
   // stored registers, slot 0 is the read-only identity word
   localparam int PVB_REG_COUNT = 48;
   localparam int PVB_IDENT_SLOT = 0;
   localparam logic [11:0] PVB_REG_OFFSET [PVB_REG_COUNT] = '{
      12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h03c,
      12'h100, 12'h104, 12'h108, 12'h10c, 12'h114, 12'h118,
      12'h11c, 12'h120, 12'h128, 12'h12c, 12'h130, 12'h134,
      12'h13c, 12'h140, 12'h144, 12'h148, 12'h170, 12'h174,
      12'h178, 12'h17c, 12'h180, 12'h184, 12'h188, 12'h18c,
      12'h190, 12'h200, 12'h204, 12'h208, 12'h210, 12'h218,
      12'h220, 12'h224, 12'h300, 12'h304, 12'h308, 12'h30c,
      12'h310, 12'h314, 12'h318, 12'h31c, 12'h320, 12'h324
   };

   // ==========================================================
   // group reported with every answer
   typedef enum logic [1:0] {
      PVB_GRP_NONE,
      PVB_GRP_HOST_CFG,
      PVB_GRP_BACKPLANE,
      PVB_GRP_DEVICE
   } pvb_group_t;

endpackage : pvb_csr_pkg

// ---- logic/pvb_csr_map.sv ----
// register file and offset decode of the bridge control/status space
// assumes both requesters run on ref_clk and hold a request until ack
module pvb_csr_map
   import pvb_csr_pkg::*;
#(
   // arbitrary identity value, not tied to any real part
   parameter logic [31:0] IDENT_VALUE = 32'h0001_0001
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic hostReq,
   input wire logic hostWrite,
   input wire logic [pvb_csr_pkg::PVB_OFF_W-1:0] hostAddr,
   input wire logic [31:0] hostWdata,
   input wire logic [3:0] hostBe,
   output logic hostAck,
   output logic [31:0] hostRdata,
   output pvb_csr_pkg::pvb_group_t hostGroup,
   input wire logic bpReq,
   input wire logic bpWrite,
   input wire logic bpCsrSpace,
   input wire logic [pvb_csr_pkg::PVB_BP_ADDR_W-1:0] bpAddr,
   input wire logic [31:0] bpWdata,
   input wire logic [3:0] bpBe,
   output logic bpAck,
   output logic [31:0] bpRdata,
   output pvb_csr_pkg::pvb_group_t bpGroup,
   output logic [31:0] csrBits,
   output logic [31:0] csrBase
);
   import pvb_csr_pkg::*;

   // decode slices below are cut for these widths only
   if (PVB_OFF_W != 12 || PVB_BP_ADDR_W != 19) begin : gWidthCheck
      $error("unsupported offset or backplane address width");
   end

   // ==========================================================
   // byte merge
   function automatic logic [31:0] mergeBytes(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = oldVal;
      // lane b holds byte address offset+b
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = newVal[8*b +: 8];
         end
      end
      return res;
   endfunction : mergeBytes

   // ==========================================================
   // arbitration, host first
   logic hostTake;
   logic bpTake;
   logic bpInWindow;
   logic [11:0] bpOff;

   // a request is not retaken in its own ack cycle
   assign hostTake = hostReq && !hostAck;
   // the backplane only waits here, it is never refused
   assign bpTake = bpReq && !bpAck && !hostTake;

   always_comb begin
      bpOff = bpAddr[11:0];
      if (bpCsrSpace) begin
         // above the base the low bits are the offset
         bpInWindow = bpAddr[18:12] == PVB_CRCSR_BASE[18:12];
      end else begin
         // register image uses the host offsets as they are
         bpInWindow = bpAddr[18:12] == 7'h00;
      end
   end

   // ==========================================================
   // selected access
   logic selValid;
   logic selWrite;
   logic [11:0] selOff;
   logic [31:0] selWdata;
   logic [3:0] selBe;
   logic wrEn;
   logic [31:0] wrMask;

   always_comb begin
      selValid = 1'b0;
      selWrite = 1'b0;
      selOff = 12'h000;
      selWdata = 32'h0000_0000;
      selBe = 4'h0;
      if (hostTake) begin
         selValid = 1'b1;
         selWrite = hostWrite;
         selOff = hostAddr;
         selWdata = hostWdata;
         selBe = hostBe;
      end else if (bpTake) begin
         selValid = bpInWindow;
         selWrite = bpWrite;
         selOff = bpOff;
         selWdata = bpWdata;
         selBe = bpBe;
      end
   end

   assign wrEn = selValid && selWrite;
   assign wrMask = mergeBytes(32'h0000_0000, selWdata, selBe);

   // ==========================================================
   // word decode
   logic [PVB_REG_COUNT-1:0] hit;
   logic [31:0] slotValue [PVB_REG_COUNT];
   logic [31:0] regFile [1:PVB_REG_COUNT-1];
   logic clrHit;
   logic setHit;
   logic baseHit;
   logic anyHit;

   // byte bits 1:0 are ignored, every register is one word
   assign clrHit = selValid && selOff[11:2] == PVB_CSR_CLR_OFF[11:2];
   assign setHit = selValid && selOff[11:2] == PVB_CSR_SET_OFF[11:2];
   assign baseHit = selValid && selOff[11:2] == PVB_CSR_BASE_OFF[11:2];
   assign anyHit = (|hit) || clrHit || setHit || baseHit;

   genvar gi;
   generate
      for (gi = 0; gi < PVB_REG_COUNT; gi++) begin : gSlot
         assign hit[gi] = selValid &&
            selOff[11:2] == PVB_REG_OFFSET[gi][11:2];
         if (gi == PVB_IDENT_SLOT) begin : gIdent
            assign slotValue[gi] = IDENT_VALUE;
         end else begin : gStore
            assign slotValue[gi] = regFile[gi];
            always_ff @(posedge ref_clk) begin
               if (!rst_b) begin
                  regFile[gi] <= PVB_REG_RESET;
               end else if (wrEn && hit[gi]) begin
                  regFile[gi] <= mergeBytes(regFile[gi], selWdata, selBe);
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // backplane csr words
   // clear and set are write-one strobes onto one shared word
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         csrBits <= PVB_REG_RESET;
      end else if (wrEn && clrHit) begin
         csrBits <= csrBits & ~wrMask;
      end else if (wrEn && setHit) begin
         csrBits <= csrBits | wrMask;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         csrBase <= PVB_REG_RESET;
      end else if (wrEn && baseHit) begin
         csrBase <= mergeBytes(csrBase, selWdata, selBe);
      end
   end

   // ==========================================================
   // read data and group
   logic [31:0] rdMux;
   pvb_group_t selGroup;

   always_comb begin
      // gaps and reserved words fall through to zero
      rdMux = PVB_UNMAPPED_DATA;
      for (int i = 0; i < PVB_REG_COUNT; i++) begin
         if (hit[i]) begin
            rdMux = slotValue[i];
         end
      end
      if (clrHit || setHit) begin
         rdMux = csrBits;
      end
      if (baseHit) begin
         rdMux = csrBase;
      end
   end

   always_comb begin
      if (!selValid) begin
         selGroup = PVB_GRP_NONE;
      end else if (selOff < PVB_HOST_CFG_END) begin
         selGroup = PVB_GRP_HOST_CFG;
      end else if (selOff >= PVB_BACKPLANE_START) begin
         selGroup = PVB_GRP_BACKPLANE;
      end else begin
         selGroup = PVB_GRP_DEVICE;
      end
   end

   // ==========================================================
   // host answer
   // unmapped writes still ack one cycle later
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         hostAck <= 1'b0;
      end else begin
         hostAck <= hostTake;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         hostRdata <= PVB_UNMAPPED_DATA;
         hostGroup <= PVB_GRP_NONE;
      end else if (hostTake) begin
         hostRdata <= hostWrite ? PVB_UNMAPPED_DATA : rdMux;
         hostGroup <= selGroup;
      end
   end

   // ==========================================================
   // backplane answer
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         bpAck <= 1'b0;
      end else begin
         bpAck <= bpTake;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         bpRdata <= PVB_UNMAPPED_DATA;
         bpGroup <= PVB_GRP_NONE;
      end else if (bpTake) begin
         bpRdata <= bpWrite ? PVB_UNMAPPED_DATA : rdMux;
         bpGroup <= selGroup;
      end
   end

   // ==========================================================
   // assertions
   a_host_ack_next: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      hostTake |=> hostAck ##1 !hostAck)
      else $error("host ack not a single pulse after take");

   a_bp_yields_host: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && bpReq && !bpAck) |=> !bpAck ##1 bpAck)
      else $error("backplane not served right after host");

   a_unmapped_read_zero: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && !hostWrite && !anyHit) |=> hostRdata == 32'h0)
      else $error("unmapped host read returned nonzero");

   a_unmapped_write_noop: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (selWrite && !anyHit) |=>
         csrBits == $past(csrBits) && csrBase == $past(csrBase))
      else $error("unmapped write changed csr state");

   a_lane_order: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (wrEn && hit[1] && selBe == 4'h1) |=>
         regFile[1][7:0] == $past(selWdata[7:0]) &&
         regFile[1][31:8] == $past(regFile[1][31:8]))
      else $error("byte lane 0 not stored in low byte");

   a_set_bits: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (wrEn && setHit) |=> (csrBits & $past(wrMask)) == $past(wrMask))
      else $error("set word did not set bits");

   a_clear_bits: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (wrEn && clrHit) |=> (csrBits & $past(wrMask)) == 32'h0)
      else $error("clear word did not clear bits");

   a_image_same_decode: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (bpTake && !bpWrite && !bpCsrSpace &&
         bpAddr == {7'h00, PVB_CSR_BASE_OFF}) |=>
         bpRdata == $past(csrBase))
      else $error("image read of base word mismatched");

   a_crcsr_base: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (bpTake && !bpWrite && bpCsrSpace &&
         bpAddr == (PVB_CRCSR_BASE | {7'h00, PVB_CSR_BASE_OFF})) |=>
         bpRdata == $past(csrBase))
      else $error("cr/csr read of base word mismatched");

   a_crcsr_outside: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (bpTake && !bpWrite && bpCsrSpace &&
         bpAddr[18:12] != 7'h7f) |=> bpRdata == 32'h0)
      else $error("cr/csr read below base returned data");

   a_ident_readonly: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && !hostWrite && hostAddr == 12'h000) |=>
         hostRdata == IDENT_VALUE && hostGroup == PVB_GRP_HOST_CFG)
      else $error("identity word wrong or group wrong");

   a_bp_ack_next: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      bpTake |=> bpAck ##1 !bpAck)
      else $error("backplane ack not a single pulse after take");

   a_write_rdata_zero: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && hostWrite) |=> hostRdata == 32'h0)
      else $error("host write answer carried data");

   a_bp_outside_none: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (bpTake && !bpInWindow) |=>
         bpGroup == PVB_GRP_NONE && bpRdata == 32'h0)
      else $error("backplane access outside window was served");

   a_unmapped_reg_keep: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (wrEn && !anyHit) |=>
         regFile[1] == $past(regFile[1]) && csrBits == $past(csrBits))
      else $error("unmapped write changed stored register");

   a_set_keeps_rest: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (wrEn && setHit) |=>
         (csrBits & ~$past(wrMask)) == ($past(csrBits) & ~$past(wrMask)))
      else $error("set word disturbed unselected bits");

   a_clear_keeps_rest: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (wrEn && clrHit) |=>
         (csrBits | $past(wrMask)) == ($past(csrBits) | $past(wrMask)))
      else $error("clear word disturbed unselected bits");

   a_host_cfg_group: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && hostAddr < 12'h100) |=>
         hostGroup == PVB_GRP_HOST_CFG)
      else $error("low offset not in host config group");

   a_device_group: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && hostAddr >= 12'h100 &&
         hostAddr < 12'hf70) |=>
         hostGroup == PVB_GRP_DEVICE)
      else $error("middle offset not in device group");

   a_bp_group_top: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && hostAddr >= 12'hf70) |=>
         hostGroup == PVB_GRP_BACKPLANE)
      else $error("top offset not in backplane csr group");

   a_word_decode: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (hostTake && !hostWrite &&
         hostAddr[11:2] == 10'h3ff) |=>
         hostRdata == $past(csrBase))
      else $error("byte bits of offset changed the word read");

endmodule : pvb_csr_map

// ---- verif/pvb_req_model.sv ----
// requester model standing in for a host or backplane master
// assumes one ref_clk domain and one ack pulse per taken request
module pvb_req_model #(
   parameter int AW = 12
) (
   input wire logic ref_clk,
   output logic req,
   output logic write,
   output logic [AW-1:0] addr,
   output logic [31:0] wdata,
   output logic [3:0] be,
   input wire logic ack,
   input wire logic [31:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      req = 1'b0;
      write = 1'b0;
      addr = '1;
      wdata = '1;
      be = '0;
   end

   // ==========================================================
   // one word access, held until the ack edge
   task automatic xfer(input logic w, input logic [AW-1:0] a,
         input logic [31:0] d, input logic [3:0] b,
         output logic [31:0] q, output logic ok);
      int n;
      n = 0;
      req <= 1'b1;
      write <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      @(posedge ref_clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      q = rdata;
      ok = (n < 20);
      // released lines show junk so stale values cannot pass
      req <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      @(posedge ref_clk);
   endtask : xfer
endmodule : pvb_req_model

// ---- verif/pvb_csr_map_test.sv ----
// self-checking bench for the bridge control/status register map
// assumes the map and two requester models share ref_clk
module pvb_csr_map_test
   import pvb_csr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [2:0] k;
      logic [18:0] a;
      logic [31:0] d;
      logic [3:0] b;
      logic [31:0] q;
      pvb_group_t g;
   } pvb_row_t;

   // arbitrary identity value, not tied to any real part
   localparam logic [31:0] ID = 32'h0000_5a5a;
   localparam int NROW = 18;

   logic ref_clk, rst_b, bpCsrSpace;
   logic hostReq, hostWrite, hostAck, bpReq, bpWrite, bpAck;
   logic [11:0] hostAddr;
   logic [18:0] bpAddr;
   logic [31:0] hostWdata, hostRdata, bpWdata, bpRdata, csrBits, csrBase;
   logic [3:0] hostBe, bpBe;
   pvb_group_t hostGroup, bpGroup;
   int errors, nTests;
   logic [31:0] q, qh;
   logic ok, okh;

   // ==========================================================
   // rows: k = {backplane, csr space, write}
   pvb_row_t rows [NROW] = '{
      '{3'b001, 19'h00004, 32'h1122_3344, 4'hf, '0, PVB_GRP_HOST_CFG},
      '{3'b000, 19'h00004, '0, 4'hf, 32'h1122_3344, PVB_GRP_HOST_CFG},
      '{3'b001, 19'h00324, 32'haabb_ccdd, 4'h5, '0, PVB_GRP_DEVICE},
      '{3'b000, 19'h00324, '0, 4'hf, 32'h00bb_00dd, PVB_GRP_DEVICE},
      '{3'b100, 19'h00324, '0, 4'hf, 32'h00bb_00dd, PVB_GRP_DEVICE},
      '{3'b110, 19'h7f324, '0, 4'hf, 32'h00bb_00dd, PVB_GRP_DEVICE},
      '{3'b100, 19'h01324, '0, 4'hf, '0, PVB_GRP_NONE},
      '{3'b001, 19'h00014, 32'hdead_beef, 4'hf, '0, PVB_GRP_HOST_CFG},
      '{3'b000, 19'h00014, '0, 4'hf, '0, PVB_GRP_HOST_CFG},
      '{3'b000, 19'h00400, '0, 4'hf, '0, PVB_GRP_DEVICE},
      '{3'b001, 19'h00ff8, 32'h0000_00f0, 4'hf, '0, PVB_GRP_BACKPLANE},
      '{3'b111, 19'h7fff4, 32'h0000_0030, 4'hf, '0, PVB_GRP_BACKPLANE},
      '{3'b000, 19'h00ff4, '0, 4'hf, 32'h0000_00c0, PVB_GRP_BACKPLANE},
      '{3'b111, 19'h7fffc, 32'h1234_5678, 4'hf, '0, PVB_GRP_BACKPLANE},
      '{3'b000, 19'h00ffc, '0, 4'hf, 32'h1234_5678, PVB_GRP_BACKPLANE},
      '{3'b001, 19'h00000, 32'hffff_ffff, 4'hf, '0, PVB_GRP_HOST_CFG},
      '{3'b000, 19'h00000, '0, 4'hf, ID, PVB_GRP_HOST_CFG},
      '{3'b000, 19'h00326, '0, 4'hf, 32'h00bb_00dd, PVB_GRP_DEVICE}
   };

   pvb_csr_map #(.IDENT_VALUE(ID)) i_dut (.ref_clk, .rst_b, .hostReq,
      .hostWrite, .hostAddr, .hostWdata, .hostBe, .hostAck, .hostRdata,
      .hostGroup, .bpReq, .bpWrite, .bpCsrSpace, .bpAddr, .bpWdata, .bpBe,
      .bpAck, .bpRdata, .bpGroup, .csrBits, .csrBase);
   pvb_req_model #(.AW(12)) i_host (.ref_clk, .req(hostReq),
      .write(hostWrite), .addr(hostAddr), .wdata(hostWdata), .be(hostBe),
      .ack(hostAck), .rdata(hostRdata));
   pvb_req_model #(.AW(19)) i_bp (.ref_clk, .req(bpReq), .write(bpWrite),
      .addr(bpAddr), .wdata(bpWdata), .be(bpBe), .ack(bpAck),
      .rdata(bpRdata));

   // ==========================================================
   // checking and closing
   task automatic check(input string nm, input logic [31:0] seen, exp);
      nTests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d errors %0d", nTests, errors);
      if (errors == 0 && nTests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // reserved words are never written, only unimplemented ones
   task automatic run(input pvb_row_t r);
      if (r.k[2]) begin
         bpCsrSpace <= r.k[1];
         i_bp.xfer(r.k[0], r.a, r.d, r.b, q, ok);
         check("bp group", 32'(bpGroup), 32'(r.g));
      end else begin
         i_host.xfer(r.k[0], r.a[11:0], r.d, r.b, q, ok);
         check("host group", 32'(hostGroup), 32'(r.g));
      end
      check("ack", 32'(ok), 32'h1);
      check("rdata", q, r.q);
      if (ok !== 1'b1)
         summarize();
   endtask : run

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      bpCsrSpace = 1'b0;
      errors = 0;
      nTests = 0;
      repeat (8) @(posedge ref_clk);
      check("reset ack", 32'(hostAck), 32'h0);
      check("reset bits", csrBits, 32'h0);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < NROW; i++)
         run(rows[i]);
      check("csr bits", csrBits, 32'h0000_00c0);
      check("csr base", csrBase, 32'h1234_5678);
      // both ports at once: host wins, backplane must still land
      fork
         i_host.xfer(1'b1, 12'h100, 32'h0f0f_0f0f, 4'hf, qh, okh);
         run('{3'b111, 19'h7f104, 32'h7777_1111, 4'hc, '0, PVB_GRP_DEVICE});
      join
      check("host ack", 32'(okh), 32'h1);
      run('{3'b100, 19'h00100, '0, 4'hf, 32'h0f0f_0f0f, PVB_GRP_DEVICE});
      run('{3'b000, 19'h00104, '0, 4'hf, 32'h7777_0000, PVB_GRP_DEVICE});
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check("reset base", csrBase, 32'h0);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      run('{3'b000, 19'h00004, '0, 4'hf, '0, PVB_GRP_HOST_CFG});
      summarize();
   end
endmodule : pvb_csr_map_test
